/* File: hw/dtb_debug_trigger.sv */
// debug trigger and breakpoint logic, top level
`include "dtb_defs.svh"
module dtb_debug_trigger (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire dtb_pkg::dtb_idx_t reg_idx,
  input wire dtb_pkg::dtb_word_t reg_wdata,
  output dtb_pkg::dtb_word_t reg_rdata,
  input wire logic bdc_wr_ctrl,
  input wire logic bdc_wr_bkpt,
  input wire dtb_pkg::dtb_word_t bdc_wdata,
  output dtb_pkg::dtb_byte_t bdc_status,
  output dtb_pkg::dtb_word_t bdc_bkpt,
  input wire logic bdc_access,
  input wire logic cpu_bg_active,
  input wire logic cpu_wait_stop,
  input wire logic cpu_wait_fail,
  input wire logic cpu_data_fail,
  input wire logic cpu_bus_valid,
  input wire dtb_pkg::dtb_word_t cpu_addr,
  input wire dtb_pkg::dtb_byte_t cpu_rdata,
  input wire dtb_pkg::dtb_byte_t cpu_wdata,
  input wire logic cpu_rw,
  input wire logic cpu_fetch,
  input wire logic cpu_exec,
  input wire logic cpu_flush,
  input wire logic cof_valid,
  input wire dtb_pkg::dtb_word_t cof_addr,
  output logic break_tag,
  output logic break_force,
  output logic break_soft_int,
  output logic trigger_pulse,
  output logic run_active_flag,
  output logic comm_clock_select
);
  import dtb_pkg::*;

  dtb_word_t comp_a_reg, comp_b_reg;
  dtb_byte_t debug_control_reg, trigger_config_reg;
  logic comp_a_hit_flag, comp_b_hit_flag;
  logic started_reg;
  logic background_permit, bkpt_en_reg, bkpt_fts_reg;
  dtb_mode_t mode;
  logic debug_module_enable, cpu_break_enable, tag_sel;
  logic dir_qual_enable_a, dir_match_a, dir_qual_enable_b, dir_match_b;
  logic opcode_qualify_select, begin_sel, event_mode, eff_begin;
  logic [3:0] trigger_mode_field;
  logic bus_ok, a_eq, b_eq, dir_ok_a, dir_ok_b, d_eq;
  logic a_m, b_m, a_hit, b_hit, a_q, b_q, in_range;
  dtb_byte_t data_sel;
  logic trig, tag_trig, arm_wr, arm_set, stop_wr, run_end;
  logic fifo_push, fifo_pop, fifo_full;
  dtb_word_t fifo_din, fifo_head;
  dtb_cnt_t fifo_word_count;

  assign debug_module_enable = debug_control_reg[`DTB_C_ENABLE];
  assign tag_sel = debug_control_reg[`DTB_C_TAG];
  assign cpu_break_enable = debug_control_reg[`DTB_C_BREAK_EN];
  assign dir_qual_enable_a = debug_control_reg[`DTB_C_DIR_QUAL_A];
  assign dir_match_a = debug_control_reg[`DTB_C_DIR_A];
  assign dir_qual_enable_b = debug_control_reg[`DTB_C_DIR_QUAL_B];
  assign dir_match_b = debug_control_reg[`DTB_C_DIR_B];
  assign opcode_qualify_select = trigger_config_reg[`DTB_T_OPSEL];
  assign begin_sel = trigger_config_reg[`DTB_T_BEGIN];
  assign trigger_mode_field = trigger_config_reg[3:0];

  // mode decode; unused codes fall to a mode that never fires
  always_comb begin
    case (trigger_mode_field)
      `DTB_M_A_ONLY: mode = DTB_A_ONLY;
      `DTB_M_A_OR_B: mode = DTB_A_OR_B;
      `DTB_M_A_THEN_B: mode = DTB_A_THEN_B;
      `DTB_M_EV_B: mode = DTB_EV_B;
      `DTB_M_A_THEN_EV_B: mode = DTB_A_THEN_EV_B;
      `DTB_M_A_AND_D: mode = DTB_A_AND_D;
      `DTB_M_A_NOT_D: mode = DTB_A_NOT_D;
      `DTB_M_INSIDE: mode = DTB_INSIDE;
      `DTB_M_OUTSIDE: mode = DTB_OUTSIDE;
      default: mode = DTB_RESERVED;
    endcase
  end

  assign event_mode = (mode == DTB_EV_B) || (mode == DTB_A_THEN_EV_B);
  assign eff_begin = begin_sel || event_mode;

  // comparators and qualifiers
  assign bus_ok = cpu_bus_valid && !bdc_access;
  assign a_eq = (cpu_addr == comp_a_reg);
  assign b_eq = (cpu_addr == comp_b_reg);
  assign dir_ok_a = !dir_qual_enable_a || (cpu_rw == dir_match_a);
  assign dir_ok_b = !dir_qual_enable_b || (cpu_rw == dir_match_b);
  // write bus when qualifying A on writes, read bus otherwise
  assign data_sel = (dir_qual_enable_a && !dir_match_a) ?
                    cpu_wdata : cpu_rdata;
  assign d_eq = (data_sel == comp_b_reg[7:0]);
  assign a_m = bus_ok && a_eq && dir_ok_a;
  assign b_m = bus_ok && b_eq && dir_ok_b;
  assign in_range = (cpu_addr >= comp_a_reg) && (cpu_addr <= comp_b_reg);

  dtb_opcode_track u_track_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .fetch(cpu_fetch && !bdc_access),
    .mark(a_eq && dir_ok_a),
    .exec(cpu_exec),
    .flush(cpu_flush),
    .hit(a_hit)
  );

  dtb_opcode_track u_track_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .fetch(cpu_fetch && !bdc_access),
    .mark(b_eq && dir_ok_b),
    .exec(cpu_exec),
    .flush(cpu_flush),
    .hit(b_hit)
  );

  assign a_q = opcode_qualify_select ? a_hit : a_m;
  assign b_q = opcode_qualify_select ? b_hit : b_m;

  always_comb begin
    case (mode)
      DTB_A_ONLY: trig = a_q;
      DTB_A_OR_B: trig = a_q || b_q;
      DTB_A_THEN_B: trig = b_q && comp_a_hit_flag;
      DTB_EV_B: trig = b_q;
      DTB_A_THEN_EV_B: trig = b_q && comp_a_hit_flag;
      DTB_A_AND_D: trig = a_q && d_eq;
      DTB_A_NOT_D: trig = a_q && !d_eq;
      DTB_INSIDE: trig = bus_ok && dir_ok_a && in_range;
      DTB_OUTSIDE: trig = bus_ok && dir_ok_a && !in_range;
      default: trig = 1'b0;
    endcase
  end

  // tag breaks in full modes skip the data compare
  always_comb begin
    case (mode)
      DTB_A_AND_D: tag_trig = a_q;
      DTB_A_NOT_D: tag_trig = a_q;
      default: tag_trig = trig;
    endcase
  end

  // register port writes
  assign arm_wr = reg_wr && (reg_idx == `DTB_IDX_CTRL);
  assign arm_set = arm_wr && reg_wdata[`DTB_C_ARM] &&
                   reg_wdata[`DTB_C_ENABLE];
  assign stop_wr = arm_wr && (!reg_wdata[`DTB_C_ARM] ||
                   !reg_wdata[`DTB_C_ENABLE]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      comp_a_reg <= `DTB_RESET_WORD;
      comp_b_reg <= `DTB_RESET_WORD;
      debug_control_reg <= `DTB_RESET_BYTE;
      trigger_config_reg <= `DTB_RESET_BYTE;
    end else if (reg_wr) begin
      case (reg_idx)
        `DTB_IDX_COMP_A: comp_a_reg <= reg_wdata;
        `DTB_IDX_COMP_B: comp_b_reg <= reg_wdata;
        `DTB_IDX_CTRL: debug_control_reg <= reg_wdata[7:0];
        `DTB_IDX_TRIG: trigger_config_reg <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // run state
  assign run_end = eff_begin ? fifo_full : trig;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_active_flag <= 1'b0;
    end else if (arm_set) begin
      run_active_flag <= 1'b1;
    end else if (stop_wr) begin
      run_active_flag <= 1'b0;
    end else if (run_active_flag && run_end) begin
      run_active_flag <= 1'b0;
    end
  end

  // hit flags: a hit while running still sets the flag in a re-arming cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      comp_a_hit_flag <= 1'b0;
      comp_b_hit_flag <= 1'b0;
    end else begin
      if (run_active_flag && a_q) begin
        comp_a_hit_flag <= 1'b1;
      end else if (arm_set) begin
        comp_a_hit_flag <= 1'b0;
      end
      if (run_active_flag && b_q) begin
        comp_b_hit_flag <= 1'b1;
      end else if (arm_set) begin
        comp_b_hit_flag <= 1'b0;
      end
    end
  end

  // begin capture opens at the trigger
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      started_reg <= 1'b0;
    end else if (arm_set) begin
      started_reg <= 1'b0;
    end else if (run_active_flag && trig) begin
      started_reg <= 1'b1;
    end
  end

  // fifo feed: data bytes in event modes, flow addresses otherwise
  always_comb begin
    fifo_push = 1'b0;
    fifo_din = cof_addr;
    if (run_active_flag) begin
      if (event_mode) begin
        fifo_push = trig;
        fifo_din = {8'h00, data_sel};
      end else if (eff_begin) begin
        fifo_push = cof_valid && started_reg;
      end else begin
        fifo_push = cof_valid;
      end
    end
  end

  assign fifo_pop = reg_rd && (reg_idx == `DTB_IDX_FIFO_LO);

  dtb_trace_fifo u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(arm_set),
    .push(fifo_push),
    .circular(!eff_begin),
    .din(fifo_din),
    .pop(fifo_pop),
    .head(fifo_head),
    .count(fifo_word_count),
    .full(fifo_full)
  );

  // breakpoint requests to the cpu
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      break_tag <= 1'b0;
      break_force <= 1'b0;
      break_soft_int <= 1'b0;
      trigger_pulse <= 1'b0;
    end else begin
      trigger_pulse <= run_active_flag && trig;
      break_tag <= run_active_flag && cpu_break_enable && tag_sel &&
                   tag_trig;
      break_force <= run_active_flag && cpu_break_enable && !tag_sel &&
                     trig;
      break_soft_int <= !background_permit;
    end
  end

  // register port read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `DTB_RESET_WORD;
    end else if (reg_rd) begin
      case (reg_idx)
        `DTB_IDX_COMP_A: reg_rdata <= comp_a_reg;
        `DTB_IDX_COMP_B: reg_rdata <= comp_b_reg;
        `DTB_IDX_CTRL: reg_rdata <= {8'h00, debug_control_reg};
        `DTB_IDX_TRIG: reg_rdata <= {8'h00, trigger_config_reg};
        `DTB_IDX_STAT: reg_rdata <= {8'h00, comp_a_hit_flag,
                        comp_b_hit_flag, run_active_flag, 1'b0,
                        fifo_word_count};
        `DTB_IDX_FIFO_HI: reg_rdata <= {8'h00, fifo_head[15:8]};
        `DTB_IDX_FIFO_LO: reg_rdata <= {8'h00, fifo_head[7:0]};
        default: reg_rdata <= `DTB_RESET_WORD;
      endcase
    end
  end

  // background controller registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      background_permit <= 1'b0;
      bkpt_en_reg <= 1'b0;
      bkpt_fts_reg <= 1'b0;
      comm_clock_select <= 1'b0;
    end else if (bdc_wr_ctrl) begin
      if (!cpu_bg_active) begin
        background_permit <= bdc_wdata[`DTB_S_PERMIT];
      end
      bkpt_en_reg <= bdc_wdata[`DTB_S_BKPTEN];
      bkpt_fts_reg <= bdc_wdata[`DTB_S_FTS];
      comm_clock_select <= bdc_wdata[`DTB_S_CLK_SEL];
    end
  end

  // status bits 6 and 2:0 follow the cpu, bits 7 and 5:3 the write command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bdc_status <= `DTB_RESET_BYTE;
    end else begin
      bdc_status <= {background_permit, cpu_bg_active, bkpt_en_reg,
                     bkpt_fts_reg, comm_clock_select, cpu_wait_stop,
                     cpu_wait_fail, cpu_data_fail};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bdc_bkpt <= `DTB_RESET_WORD;
    end else if (bdc_wr_bkpt) begin
      bdc_bkpt <= bdc_wdata;
    end
  end
endmodule // dtb_debug_trigger

/* File: hw/dtb_opcode_track.sv */
// opcode tracker: follows a marked fetch through the instruction queue
`include "dtb_defs.svh"
module dtb_opcode_track (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fetch,
  input wire logic mark,
  input wire logic exec,
  input wire logic flush,
  output logic hit
);
  import dtb_pkg::*;
  logic [`DTB_QUEUE_DEPTH-1:0] q_reg, q_next, q_pop;
  logic [`DTB_QCNT_W-1:0] n_reg, n_next, n_pop;
  logic pop;

  assign pop = exec && (n_reg != '0);

  always_comb begin
    q_pop = pop ? (q_reg >> 1) : q_reg;
    n_pop = pop ? n_reg - 3'h1 : n_reg;
    q_next = q_pop;
    n_next = n_pop;
    if (flush) begin
      q_next = '0;
      n_next = '0;
    end else if (fetch && n_pop < 3'(`DTB_QUEUE_DEPTH)) begin
      q_next[n_pop[1:0]] = mark;
      n_next = n_pop + 3'h1;
    end
  end

  // discarded opcodes vanish with the flush and never hit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg <= '0;
      n_reg <= '0;
      hit <= 1'b0;
    end else begin
      q_reg <= q_next;
      n_reg <= n_next;
      hit <= pop && q_reg[0] && !flush;
    end
  end
endmodule // dtb_opcode_track

/* File: hw/dtb_trace_fifo.sv */
// eight word trace fifo with optional circular overwrite
`include "dtb_defs.svh"
module dtb_trace_fifo (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic push,
  input wire logic circular,
  input wire dtb_pkg::dtb_word_t din,
  input wire logic pop,
  output dtb_pkg::dtb_word_t head,
  output dtb_pkg::dtb_cnt_t count,
  output logic full
);
  import dtb_pkg::*;
  dtb_word_t mem [`DTB_FIFO_DEPTH];
  logic [2:0] wp_reg, rp_reg;
  logic do_push, do_pop, drop;

  assign full = (count == 4'(`DTB_FIFO_DEPTH));
  assign head = mem[rp_reg];
  assign do_pop = pop && (count != '0);
  // circular store drops the oldest word when full
  assign drop = push && full && circular;
  assign do_push = push && (!full || circular);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_reg] <= din;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count <= '0;
    end else if (clear) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wp_reg <= wp_reg + 3'h1;
      end
      if (do_pop || drop) begin
        rp_reg <= rp_reg + 3'h1;
      end
      if (do_push && !drop && !do_pop) begin
        count <= count + 4'h1;
      end else if (do_pop && !do_push) begin
        count <= count - 4'h1;
      end
    end
  end
endmodule // dtb_trace_fifo

/* File: shared/dtb_defs.svh */
// constants of the debug trigger and breakpoint block
`ifndef DTB_DEFS_SVH
`define DTB_DEFS_SVH
`define DTB_FIFO_DEPTH 8
`define DTB_CNT_W 4
`define DTB_QUEUE_DEPTH 4
`define DTB_QCNT_W 3
// register indices on the register port
`define DTB_IDX_COMP_A 3'h0
`define DTB_IDX_COMP_B 3'h1
`define DTB_IDX_CTRL 3'h2
`define DTB_IDX_TRIG 3'h3
`define DTB_IDX_STAT 3'h4
`define DTB_IDX_FIFO_HI 3'h5
`define DTB_IDX_FIFO_LO 3'h6
// debug_control_reg bits
`define DTB_C_ENABLE 7
`define DTB_C_ARM 6
`define DTB_C_TAG 5
`define DTB_C_BREAK_EN 4
`define DTB_C_DIR_QUAL_A 3
`define DTB_C_DIR_A 2
`define DTB_C_DIR_QUAL_B 1
`define DTB_C_DIR_B 0
// trigger_config_reg bits
`define DTB_T_OPSEL 7
`define DTB_T_BEGIN 6
// bg_status_control bits
`define DTB_S_PERMIT 7
`define DTB_S_ACTIVE 6
`define DTB_S_BKPTEN 5
`define DTB_S_FTS 4
`define DTB_S_CLK_SEL 3
`define DTB_S_WAIT 2
`define DTB_S_WAIT_FAIL 1
`define DTB_S_DATA_FAIL 0
// trigger_mode_field encodings
`define DTB_M_A_ONLY 4'h0
`define DTB_M_A_OR_B 4'h1
`define DTB_M_A_THEN_B 4'h2
`define DTB_M_EV_B 4'h3
`define DTB_M_A_THEN_EV_B 4'h4
`define DTB_M_A_AND_D 4'h5
`define DTB_M_A_NOT_D 4'h6
`define DTB_M_INSIDE 4'h7
`define DTB_M_OUTSIDE 4'h8
`define DTB_RESET_BYTE 8'h00
`define DTB_RESET_WORD 16'h0000
`endif

/* File: shared/dtb_pkg.sv */
// types of the debug trigger and breakpoint block
`include "dtb_defs.svh"
package dtb_pkg;
  typedef logic [15:0] dtb_word_t;
  typedef logic [7:0] dtb_byte_t;
  typedef logic [2:0] dtb_idx_t;
  typedef logic [`DTB_CNT_W-1:0] dtb_cnt_t;
  typedef enum logic [3:0] {
    DTB_A_ONLY, DTB_A_OR_B, DTB_A_THEN_B, DTB_EV_B, DTB_A_THEN_EV_B,
    DTB_A_AND_D, DTB_A_NOT_D, DTB_INSIDE, DTB_OUTSIDE, DTB_RESERVED
  } dtb_mode_t;
endpackage

/* File: verification/dtb_cpu_model.sv */
// cpu pipeline model on the far side of the debug trigger block
module dtb_cpu_model (
  input wire logic clk,
  input wire logic break_tag,
  input wire logic break_force,
  input wire logic break_soft_int,
  output logic cpu_bus_valid,
  output dtb_pkg::dtb_word_t cpu_addr,
  output dtb_pkg::dtb_byte_t cpu_rdata,
  output dtb_pkg::dtb_byte_t cpu_wdata,
  output logic cpu_rw,
  output logic cpu_fetch,
  output logic cpu_exec,
  output logic cpu_flush,
  output logic cpu_bg_active,
  output logic cof_valid,
  output dtb_pkg::dtb_word_t cof_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  import dtb_pkg::*;
  int n_bg = 0;
  int n_soft_int = 0;
  logic tag_pend = 1'b0;
  initial begin
    {cpu_bus_valid, cpu_fetch, cpu_exec, cpu_flush} = 4'h0;
    {cpu_rw, cpu_bg_active, cof_valid} = 3'h4;
    {cpu_addr, cof_addr, cpu_rdata, cpu_wdata} = 48'h0;
  end
  // background when permitted, else software interrupt
  always @(posedge clk) begin
    if (cpu_flush || cpu_exec) tag_pend <= 1'b0;
    else if (break_tag) tag_pend <= 1'b1;
    if (break_force || (tag_pend && cpu_exec)) begin
      if (break_soft_int) n_soft_int++;
      else begin
        n_bg++;
        cpu_bg_active <= 1'b1;
      end
    end
  end
  // released buses show the inverse of the last value
  task automatic bus(dtb_word_t a, dtb_byte_t rd, dtb_byte_t wd, logic rw,
      logic f);
    @(posedge clk);
    {cpu_bus_valid, cpu_addr, cpu_rdata, cpu_wdata} <= {1'b1, a, rd, wd};
    {cpu_rw, cpu_fetch} <= {rw, f};
    @(posedge clk);
    {cpu_bus_valid, cpu_fetch} <= 2'h0;
    {cpu_addr, cpu_rdata, cpu_wdata} <= ~{a, rd, wd};
  endtask
  task automatic step(logic fl);
    @(posedge clk);
    {cpu_exec, cpu_flush} <= {~fl, fl};
    @(posedge clk);
    {cpu_exec, cpu_flush} <= 2'h0;
  endtask
  task automatic cof(dtb_word_t a);
    @(posedge clk);
    {cof_valid, cof_addr} <= {1'b1, a};
    @(posedge clk);
    {cof_valid, cof_addr} <= {1'b0, ~a};
  endtask
endmodule // dtb_cpu_model

/* File: verification/dtb_debug_trigger_props.sv */
// assertion checker for the debug trigger block
`include "dtb_defs.svh"
module dtb_debug_trigger_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire dtb_pkg::dtb_idx_t reg_idx,
  input wire dtb_pkg::dtb_word_t reg_wdata,
  input wire logic bdc_wr_ctrl,
  input wire dtb_pkg::dtb_word_t bdc_wdata,
  input wire dtb_pkg::dtb_byte_t bdc_status,
  input wire logic bdc_access,
  input wire logic cpu_bg_active,
  input wire logic cpu_wait_stop,
  input wire logic cpu_wait_fail,
  input wire logic cpu_data_fail,
  input wire logic break_tag,
  input wire logic break_force,
  input wire logic break_soft_int,
  input wire logic trigger_pulse,
  input wire logic run_active_flag
);
  import dtb_pkg::*;
  logic [7:0] cfg_reg;
  wire ctl_wr = reg_wr && reg_idx == `DTB_IDX_CTRL;
  wire [3:0] mirror = {cpu_bg_active, cpu_wait_stop, cpu_wait_fail,
                       cpu_data_fail};
  // shadow of the trigger configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cfg_reg <= 8'h00;
    else if (reg_wr && reg_idx == `DTB_IDX_TRIG) cfg_reg <= reg_wdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_arm_sets_flag: assert property (
    ctl_wr && reg_wdata[7:6] == 2'h3 |=> run_active_flag)
    else $error("arm write left run idle");
  chk_stop_ends_run: assert property (
    ctl_wr && reg_wdata[7:6] != 2'h3 |=> !run_active_flag)
    else $error("run kept after stop write");
  chk_idle_no_trig: assert property (
    !run_active_flag |=> !trigger_pulse)
    else $error("trigger while not armed");
  chk_bdc_no_match: assert property (
    bdc_access |=> !trigger_pulse)
    else $error("trigger on background access");
  chk_end_run_stops: assert property (
    trigger_pulse && !cfg_reg[6] && !(cfg_reg[3:0] inside {4'h3, 4'h4})
    |-> !run_active_flag) else $error("end run kept going");
  chk_reserved_quiet: assert property (
    trigger_pulse |-> cfg_reg[3:0] < 4'h9)
    else $error("trigger in reserved mode");
  chk_permit_locked: assert property (
    bdc_wr_ctrl && cpu_bg_active |=> ##1 $stable(bdc_status[7]))
    else $error("permit written while active");
  chk_status_mirror: assert property (
    $stable(mirror)[*3] |-> {bdc_status[6], bdc_status[2:0]} == mirror)
    else $error("status bits not mirrored");
  chk_clock_sel_write: assert property (
    bdc_wr_ctrl ##1 !bdc_wr_ctrl |=> bdc_status[3] == $past(bdc_wdata[3], 2))
    else $error("clock select not written");
  chk_soft_int_fallback: assert property (
    bdc_wr_ctrl && !cpu_bg_active && !bdc_wdata[7] |=> ##1 break_soft_int)
    else $error("no software interrupt fallback");
  chk_one_break_kind: assert property (
    !(break_tag && break_force)) else $error("tag and force together");
  cover property (trigger_pulse);
  cover property (break_tag);
  cover property (break_force);
  cover property (bdc_wr_ctrl && cpu_bg_active);
endmodule // dtb_debug_trigger_props
bind dtb_debug_trigger dtb_debug_trigger_props dtb_debug_trigger_props_inst (
  .clk, .sys_rst, .reg_wr, .reg_idx, .reg_wdata, .bdc_wr_ctrl, .bdc_wdata,
  .bdc_status, .bdc_access, .cpu_bg_active, .cpu_wait_stop, .cpu_wait_fail,
  .cpu_data_fail, .break_tag, .break_force, .break_soft_int, .trigger_pulse,
  .run_active_flag);

/* File: verification/dtb_debug_trigger_test.sv */
// self-checking bench for the debug trigger block
`include "dtb_defs.svh"
module dtb_debug_trigger_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dtb_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  dtb_idx_t reg_idx = 3'h0;
  dtb_word_t reg_wdata = 16'h0000;
  logic bdc_wr_ctrl = 1'b0;
  logic bdc_wr_bkpt = 1'b0;
  dtb_word_t bdc_wdata = 16'h0000;
  logic bdc_access = 1'b0;
  logic [2:0] wsd = 3'h0;
  dtb_word_t reg_rdata, bdc_bkpt, cpu_addr, cof_addr;
  dtb_byte_t bdc_status, cpu_rdata, cpu_wdata;
  logic cpu_bus_valid, cpu_rw, cpu_fetch, cpu_exec, cpu_flush, cof_valid;
  logic cpu_bg_active, break_tag, break_force, break_soft_int, trigger_pulse;
  logic run_active_flag, comm_clock_select;
  logic [3:0] mode;
  int n_fail = 0;
  int check_count = 0;
  int n_trig = 0;
  int n_brk = 0;
  dtb_word_t sa[7] = '{16'h0FFF, 16'h2055, 16'h1000, 16'h1800, 16'h2055,
    16'h1000, 16'h2056};
  dtb_byte_t sd[7] = '{8'h00, 8'hA5, 8'h55, 8'h00, 8'h00, 8'h11, 8'h00};
  int ex[10] = '{2, 4, 1, 2, 1, 1, 1, 5, 2, 0};
  dtb_debug_trigger dtb_debug_trigger_inst (.clk, .sys_rst, .reg_wr, .reg_rd,
    .reg_idx, .reg_wdata, .reg_rdata, .bdc_wr_ctrl, .bdc_wr_bkpt, .bdc_wdata,
    .bdc_status, .bdc_bkpt, .bdc_access, .cpu_bg_active,
    .cpu_wait_stop(wsd[2]), .cpu_wait_fail(wsd[1]),
    .cpu_data_fail(wsd[0]),
    .cpu_bus_valid, .cpu_addr, .cpu_rdata, .cpu_wdata, .cpu_rw, .cpu_fetch,
    .cpu_exec, .cpu_flush, .cof_valid, .cof_addr, .break_tag, .break_force,
    .break_soft_int, .trigger_pulse, .run_active_flag, .comm_clock_select);
  dtb_cpu_model dtb_cpu_model_inst (.clk, .break_tag, .break_force,
    .break_soft_int, .cpu_bus_valid, .cpu_addr, .cpu_rdata, .cpu_wdata,
    .cpu_rw, .cpu_fetch, .cpu_exec, .cpu_flush, .cpu_bg_active, .cof_valid,
    .cof_addr);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (trigger_pulse === 1'b1) n_trig++;
    if (break_tag === 1'b1 || break_force === 1'b1) n_brk++;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(dtb_word_t seen, dtb_word_t want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(dtb_idx_t i, dtb_word_t d);
    @(posedge clk);
    {reg_wr, reg_idx, reg_wdata} <= {1'b1, i, d};
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(dtb_idx_t i, dtb_word_t m, dtb_word_t want);
    @(posedge clk);
    {reg_rd, reg_idx} <= {1'b1, i};
    @(posedge clk);
    reg_rd <= 1'b0;
    idle(1);
    chk(reg_rdata & m, want);
  endtask
  task automatic bdc(logic k, dtb_word_t d);
    @(posedge clk);
    {bdc_wr_ctrl, bdc_wr_bkpt, bdc_wdata} <= {~k, k, d};
    @(posedge clk);
    {bdc_wr_ctrl, bdc_wr_bkpt} <= 2'h0;
    idle(3);
  endtask
  task automatic arm(dtb_word_t cfg, dtb_word_t ctl);
    wr(`DTB_IDX_TRIG, cfg);
    wr(`DTB_IDX_CTRL, ctl);
    n_trig = 0;
  endtask
  task automatic cyc(dtb_word_t a, dtb_byte_t r, dtb_byte_t w, logic rw,
      logic f);
    dtb_cpu_model_inst.bus(a, r, w, rw, f);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    idle(2);
    chk({8'h00, bdc_status}, 16'h0000);
    chk({15'h0, break_soft_int}, 16'h0001);
    wr(`DTB_IDX_COMP_A, 16'h1000);
    wr(`DTB_IDX_COMP_B, 16'h2055);
    // each mode over one bus sequence, begin type, alternate stops
    for (int m = 0; m < 10; m++) begin
      mode = (m == 9) ? 4'hF : 4'(m);
      arm({8'h00, (m == 3) ? 4'h0 : 4'h4, mode}, 16'h00C0);
      rd(`DTB_IDX_STAT, 16'h00FF, 16'h0020);
      for (int k = 0; k < 7; k++) cyc(sa[k], sd[k], 8'h00, 1'b1, 1'b0);
      idle(3);
      chk(16'(n_trig), 16'(ex[m]));
      if (m == 3) begin
        rd(`DTB_IDX_STAT, 16'h00FF, 16'h00E2);
        rd(`DTB_IDX_FIFO_LO, 16'h00FF, 16'h00A5);
        rd(`DTB_IDX_FIFO_LO, 16'h00FF, 16'h0000);
      end
      wr(`DTB_IDX_CTRL, m[0] ? 16'h0080 : 16'h0040);
      chk({15'h0, run_active_flag}, 16'h0000);
    end
    chk(16'(n_brk), 16'h0000);
    arm(16'h0000, 16'h00C0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    idle(3);
    chk({15'h0, run_active_flag}, 16'h0000);
    chk(16'(n_trig), 16'h0001);
    arm(16'h0040, 16'h00C0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++) dtb_cpu_model_inst.cof(16'h3000 + 16'(k));
    idle(3);
    chk({15'h0, run_active_flag}, 16'h0000);
    rd(`DTB_IDX_STAT, 16'h000F, 16'h0008);
    rd(`DTB_IDX_FIFO_HI, 16'h00FF, 16'h0030);
    rd(`DTB_IDX_FIFO_LO, 16'h00FF, 16'h0000);
    arm(16'h0040, 16'h00C8);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b0, 1'b0);
    idle(3);
    chk(16'(n_trig), 16'h0001);
    arm(16'h0045, 16'h00C8);
    cyc(16'h1000, 8'h55, 8'h00, 1'b0, 1'b0);
    cyc(16'h1000, 8'h00, 8'h55, 1'b0, 1'b0);
    idle(3);
    chk(16'(n_trig), 16'h0001);
    arm(16'h0040, 16'h00C0);
    @(posedge clk) bdc_access <= 1'b1;
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    bdc_access <= 1'b0;
    idle(3);
    chk(16'(n_trig), 16'h0000);
    // opcode tracking: flushed fetch is silent, two pending both fire
    arm(16'h00C1, 16'h00C0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b1);
    dtb_cpu_model_inst.step(1'b1);
    dtb_cpu_model_inst.step(1'b0);
    idle(4);
    chk(16'(n_trig), 16'h0000);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b1);
    cyc(16'h2055, 8'h00, 8'h00, 1'b1, 1'b1);
    dtb_cpu_model_inst.step(1'b0);
    dtb_cpu_model_inst.step(1'b0);
    idle(4);
    chk(16'(n_trig), 16'h0002);
    arm(16'h0040, 16'h00D0);
    n_brk = 0;
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    idle(3);
    chk({15'h0, break_force}, 16'h0000);
    arm(16'h0040, 16'h00F0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b1);
    dtb_cpu_model_inst.step(1'b0);
    idle(3);
    chk(16'(dtb_cpu_model_inst.n_soft_int), 16'h0002);
    arm(16'h0045, 16'h00F0);
    cyc(16'h1000, 8'h11, 8'h00, 1'b1, 1'b0);
    idle(3);
    chk(16'(n_trig), 16'h0000);
    chk(16'(n_brk), 16'h0003);
    bdc(1'b0, 16'h0088);
    chk({8'h00, bdc_status}, 16'h0088);
    chk({14'h0, break_soft_int, comm_clock_select}, 16'h0001);
    bdc(1'b0, 16'h0008);
    chk({14'h0, break_soft_int, comm_clock_select}, 16'h0003);
    bdc(1'b0, 16'h0088);
    arm(16'h0040, 16'h00D0);
    cyc(16'h1000, 8'h00, 8'h00, 1'b1, 1'b0);
    wsd <= 3'h7;
    idle(3);
    chk(16'(dtb_cpu_model_inst.n_bg), 16'h0001);
    bdc(1'b0, 16'h0037);
    chk({8'h00, bdc_status}, 16'h00F7);
    chk({15'h0, comm_clock_select}, 16'h0000);
    bdc(1'b1, 16'hBEEF);
    chk(bdc_bkpt, 16'hBEEF);
    report_and_stop();
  end
endmodule // dtb_debug_trigger_test
